// ---- design/irio_consts.vh ----
// register map, field positions and reset values of the port block
`ifndef IRIO_CONSTS_VH
`define IRIO_CONSTS_VH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define IRIO_ADDR_P0_MODE 6'h00
`define IRIO_ADDR_PORT_CFG 6'h04
`define IRIO_ADDR_P2_MODE 6'h08
`define IRIO_ADDR_P3_MODE 6'h0c
`define IRIO_ADDR_P0_DATA 6'h10
`define IRIO_ADDR_P2_DATA 6'h14
`define IRIO_ADDR_P3_DATA 6'h18
`define IRIO_ADDR_IRQ_CTL 6'h1c
`define IRIO_ADDR_COUNTER_CTL_0 6'h20
`define IRIO_ADDR_COUNTER_CTL_1 6'h24
`define IRIO_ADDR_COUNTER_CTL_2 6'h28
`define IRIO_ADDR_TMR_COMMON 6'h2c
`define IRIO_ADDR_WAKE_CTL 6'h30

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define IRIO_P0_MODE_LO 0
`define IRIO_P0_MODE_HI 1
`define IRIO_CFG_COMP_OUT 0
`define IRIO_CFG_P2_PUSHPULL 1
`define IRIO_CFG_P0_PUSHPULL 2
`define IRIO_P3_MODE_ANALOG 1
`define IRIO_IRQ_EDGE_LO 6
`define IRIO_IRQ_EDGE_HI 7
`define IRIO_COUNTER_CTL_0_T16_OUT 0
`define IRIO_COUNTER_CTL_1_T8_OUT 4
`define IRIO_COUNTER_CTL_1_T816_OUT 5
`define IRIO_COUNTER_CTL_2_LOGIC_OUT 0
`define IRIO_TMR_SEL_P2 0
`define IRIO_TMR_DEMOD 1
`define IRIO_WAKE_EN 0
`define IRIO_WAKE_AND 1

// ------------------------------------------------------------
// edge select codes and reset values
// ------------------------------------------------------------
`define IRIO_EDGE_FALL 2'h0
`define IRIO_EDGE_RISE 2'h1
`define IRIO_RST_P0_MODE 8'h00
`define IRIO_RST_P2_MODE 8'hff
`define IRIO_RST_ZERO 8'h00

`endif

// ---- design/irio_ports.v ----
// parallel port block: nibble port, bit port with wake gating, fixed port
//
// Local design decisions: register access over Avalon-MM and the register offsets.
`include "irio_consts.vh"
`default_nettype none

// Operation
// (R1) first port direction is set per nibble, never per bit
// (R2) first port push-pull or open-drain chosen by config bit 2
// (R3) every hardware reset makes the first port all inputs
// (R4) pull-ups are switched off on any pin driven as output
// (R5) second port direction set bit by bit, always usable for I/O
// (R6) second port outputs share one push-pull or open-drain choice
// (R7) reset makes all eight second-port bits inputs
// (R8) second port inputs ORed and ANDed, either one can wake the part
// (R9) port2_bit0 may feed timer edge detection in demodulation mode
// (R10) third port: three CMOS inputs, four push-pull outputs
// (R11) mode register bit 1 enables comparators on port3_in1, port3_in2
// (R12) port3_in1, port3_in2 interrupt on rise, fall or both per bits 7:6
// (R13) timer edge detector fed from port3_in1 or port2_bit0
// (R14) timer and logic outputs routed to third port by counter controls
// (R15) analog mode sends port3_in3 to stop recovery, not ext_int_1
// (R16) digital mode shows port3_in3 as input bit 3, raising ext_int_1
// (R17) comparators powered down in stop mode; software uses digital mode
// (R18) comparator outputs may drive port3_out4 and port3_out7
// (R19) every pin input is synchronised before any logic reads it
module irio_ports (
	input wire clock,
	input wire reset_n,
	// avalon-mm slave
	input wire [5:0] address,
	input wire read,
	input wire write,
	input wire [31:0] writedata,
	input wire [3:0] byteenable,
	output reg [31:0] readdata,
	output reg waitrequest,
	// first port pins
	input wire [7:0] port0_in,
	output reg [7:0] port0_out,
	output reg [7:0] port0_oe,
	output reg [7:0] port0_pullup_en,
	// second port pins
	input wire [7:0] port2_in,
	output reg [7:0] port2_out,
	output reg [7:0] port2_oe,
	output reg [7:0] port2_pullup_en,
	// third port pins, bit 0 of the input bus unused
	input wire [3:1] port3_in,
	output reg [7:4] port3_out,
	// comparators, timers and stop logic
	input wire comp1_result,
	input wire comp2_result,
	input wire timer8_out,
	input wire timer16_out,
	input wire timer816_out,
	input wire stop_mode,
	output reg comp_power_en,
	output reg timer_edge_in,
	output reg wake_request,
	output reg stop_recovery_in3,
	output reg ext_int_0,
	output reg ext_int_1,
	output reg ext_int_2
);

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	reg [7:0] p0_mode_q;
	reg [7:0] port_config_reg_q;
	reg [7:0] p2_mode_q;
	reg [7:0] p3_mode_q;
	reg [7:0] p0_data_q;
	reg [7:0] p2_data_q;
	reg [7:0] p3_data_q;
	reg [7:0] irq_ctl_q;
	reg [7:0] counter_ctl_0_q;
	reg [7:0] counter_ctl_1_q;
	reg [7:0] counter_ctl_2_q;
	reg [7:0] tmr_common_q;
	reg [7:0] wake_ctl_q;

	// ------------------------------------------------------------
	// input synchronisers
	// ------------------------------------------------------------
	reg [7:0] p0_meta_q;
	reg [7:0] p0_sync_q;
	reg [7:0] p2_meta_q;
	reg [7:0] p2_sync_q;
	reg [4:0] misc_meta_q;
	reg [4:0] misc_sync_q;
	reg [2:0] irq_src_prev_q;

	// edge detect: sel 0 fall, 1 rise, else both
	function edge_hit;
		input [1:0] sel;
		input prev;
		input cur;
		begin
			if (sel == `IRIO_EDGE_FALL) begin
				edge_hit = prev & ~cur;
			end else if (sel == `IRIO_EDGE_RISE) begin
				edge_hit = ~prev & cur;
			end else begin
				edge_hit = prev ^ cur;
			end
		end
	endfunction

	// open-drain drives low only; push-pull drives both levels
	function [7:0] drive_en;
		input [7:0] is_out;
		input push_pull;
		input [7:0] data;
		begin
			drive_en = is_out & ({8{push_pull}} | ~data);
		end
	endfunction

	// inputs read the pin, outputs read back the latch
	function [7:0] pin_view;
		input [7:0] pin;
		input [7:0] latch;
		input [7:0] is_out;
		begin
			pin_view = (pin & ~is_out) | (latch & is_out);
		end
	endfunction

	wire analog = p3_mode_q[`IRIO_P3_MODE_ANALOG];
	wire in1_s = misc_sync_q[0];
	wire in2_s = misc_sync_q[1];
	wire in3_s = misc_sync_q[2];
	wire cmp1_s = misc_sync_q[3];
	wire cmp2_s = misc_sync_q[4];
	// analog mode takes interrupt sources from the comparators
	wire src1 = analog ? cmp1_s : in1_s; // [R11]
	wire src2 = analog ? cmp2_s : in2_s; // [R11]
	wire [1:0] edge_sel = irq_ctl_q[`IRIO_IRQ_EDGE_HI:`IRIO_IRQ_EDGE_LO];
	wire cfg_comp = port_config_reg_q[`IRIO_CFG_COMP_OUT];
	wire [7:0] p0_dir = {{4{p0_mode_q[`IRIO_P0_MODE_HI]}},
		{4{p0_mode_q[`IRIO_P0_MODE_LO]}}}; // [R1]
	wire [7:0] p2_dir = ~p2_mode_q; // [R5]

	// ------------------------------------------------------------
	// source swap guard
	// ------------------------------------------------------------
	// flipping analog mode swaps what feeds the edge detectors while
	// their history still holds the old source: mask that one cycle
	reg analog_prev_q;
	wire src_swap = analog ^ analog_prev_q; // [R11]

	// ------------------------------------------------------------
	// bus access, one wait cycle per request
	// ------------------------------------------------------------
	wire req = read | write;
	wire take = req & ~waitrequest;
	wire wr_en = write & take & byteenable[0];
	reg [7:0] rd_byte;

	always @* begin
		if (address == `IRIO_ADDR_P0_MODE) begin
			rd_byte = p0_mode_q;
		end else if (address == `IRIO_ADDR_PORT_CFG) begin
			rd_byte = port_config_reg_q;
		end else if (address == `IRIO_ADDR_P2_MODE) begin
			rd_byte = p2_mode_q;
		end else if (address == `IRIO_ADDR_P3_MODE) begin
			rd_byte = p3_mode_q;
		end else if (address == `IRIO_ADDR_P0_DATA) begin
			rd_byte = pin_view(p0_sync_q, p0_data_q, p0_dir);
		end else if (address == `IRIO_ADDR_P2_DATA) begin
			rd_byte = pin_view(p2_sync_q, p2_data_q, p2_dir);
		end else if (address == `IRIO_ADDR_P3_DATA) begin
			// bit 3 hidden while the pin feeds stop recovery
			rd_byte = {p3_data_q[7:4], in3_s & ~analog,
				in2_s, in1_s, 1'b0}; // [R16] [R10]
		end else if (address == `IRIO_ADDR_IRQ_CTL) begin
			rd_byte = irq_ctl_q;
		end else if (address == `IRIO_ADDR_COUNTER_CTL_0) begin
			rd_byte = counter_ctl_0_q;
		end else if (address == `IRIO_ADDR_COUNTER_CTL_1) begin
			rd_byte = counter_ctl_1_q;
		end else if (address == `IRIO_ADDR_COUNTER_CTL_2) begin
			rd_byte = counter_ctl_2_q;
		end else if (address == `IRIO_ADDR_TMR_COMMON) begin
			rd_byte = tmr_common_q;
		end else if (address == `IRIO_ADDR_WAKE_CTL) begin
			rd_byte = wake_ctl_q;
		end else begin
			rd_byte = 8'h00;
		end
	end

	always @(posedge clock) begin
		if (!reset_n) begin
			waitrequest <= 1'b1;
			readdata <= 32'h00000000;
		end else begin
			// drop for exactly one cycle after a request is seen
			waitrequest <= ~(req & waitrequest);
			if (read & waitrequest) begin
				readdata <= {24'h000000, rd_byte};
			end
		end
	end

	// ------------------------------------------------------------
	// register writes
	// ------------------------------------------------------------
	always @(posedge clock) begin
		if (!reset_n) begin
			p0_mode_q <= `IRIO_RST_P0_MODE; // [R3]
			port_config_reg_q <= `IRIO_RST_ZERO;
			p2_mode_q <= `IRIO_RST_P2_MODE; // [R7]
			p3_mode_q <= `IRIO_RST_ZERO;
			p0_data_q <= `IRIO_RST_ZERO;
			p2_data_q <= `IRIO_RST_ZERO;
			p3_data_q <= `IRIO_RST_ZERO;
			irq_ctl_q <= `IRIO_RST_ZERO;
			counter_ctl_0_q <= `IRIO_RST_ZERO;
			counter_ctl_1_q <= `IRIO_RST_ZERO;
			counter_ctl_2_q <= `IRIO_RST_ZERO;
			tmr_common_q <= `IRIO_RST_ZERO;
			wake_ctl_q <= `IRIO_RST_ZERO;
		end else if (wr_en) begin
			if (address == `IRIO_ADDR_P0_MODE) begin
				p0_mode_q <= {6'h00, writedata[1:0]}; // [R1]
			end else if (address == `IRIO_ADDR_PORT_CFG) begin
				port_config_reg_q <= writedata[7:0];
			end else if (address == `IRIO_ADDR_P2_MODE) begin
				p2_mode_q <= writedata[7:0]; // [R5]
			end else if (address == `IRIO_ADDR_P3_MODE) begin
				p3_mode_q <= writedata[7:0];
			end else if (address == `IRIO_ADDR_P0_DATA) begin
				p0_data_q <= writedata[7:0];
			end else if (address == `IRIO_ADDR_P2_DATA) begin
				p2_data_q <= writedata[7:0];
			end else if (address == `IRIO_ADDR_P3_DATA) begin
				p3_data_q <= {writedata[7:4], 4'h0};
			end else if (address == `IRIO_ADDR_IRQ_CTL) begin
				irq_ctl_q <= writedata[7:0];
			end else if (address == `IRIO_ADDR_COUNTER_CTL_0) begin
				counter_ctl_0_q <= writedata[7:0];
			end else if (address == `IRIO_ADDR_COUNTER_CTL_1) begin
				counter_ctl_1_q <= writedata[7:0];
			end else if (address == `IRIO_ADDR_COUNTER_CTL_2) begin
				counter_ctl_2_q <= writedata[7:0];
			end else if (address == `IRIO_ADDR_TMR_COMMON) begin
				tmr_common_q <= writedata[7:0];
			end else if (address == `IRIO_ADDR_WAKE_CTL) begin
				wake_ctl_q <= writedata[7:0];
			end
		end
	end

	// ------------------------------------------------------------
	// synchronisers and edge history
	// ------------------------------------------------------------
	always @(posedge clock) begin
		if (!reset_n) begin
			p0_meta_q <= 8'h00;
			p0_sync_q <= 8'h00;
			p2_meta_q <= 8'h00;
			p2_sync_q <= 8'h00;
			misc_meta_q <= 5'h00;
			misc_sync_q <= 5'h00;
			irq_src_prev_q <= 3'h0;
			analog_prev_q <= 1'b0;
		end else begin
			p0_meta_q <= port0_in; // [R19]
			p0_sync_q <= p0_meta_q; // [R19]
			p2_meta_q <= port2_in; // [R19]
			p2_sync_q <= p2_meta_q; // [R19]
			misc_meta_q <= {comp2_result, comp1_result,
				port3_in}; // [R19]
			misc_sync_q <= misc_meta_q; // [R19]
			irq_src_prev_q <= {in3_s, src2, src1};
			analog_prev_q <= analog;
		end
	end

	// ------------------------------------------------------------
	// pin drive, interrupts, routing
	// ------------------------------------------------------------
	always @(posedge clock) begin
		if (!reset_n) begin
			port0_out <= 8'h00;
			port0_oe <= 8'h00;
			port0_pullup_en <= 8'hff;
			port2_out <= 8'h00;
			port2_oe <= 8'h00;
			port2_pullup_en <= 8'hff;
			port3_out <= 4'h0;
			comp_power_en <= 1'b0;
			timer_edge_in <= 1'b0;
			wake_request <= 1'b0;
			stop_recovery_in3 <= 1'b0;
			ext_int_0 <= 1'b0;
			ext_int_1 <= 1'b0;
			ext_int_2 <= 1'b0;
		end else begin
			port0_out <= p0_data_q;
			port0_oe <= drive_en(p0_dir,
				port_config_reg_q[`IRIO_CFG_P0_PUSHPULL],
				p0_data_q); // [R2]
			port0_pullup_en <= ~p0_dir; // [R4]
			port2_out <= p2_data_q;
			// one drive choice for every output bit of this port
			port2_oe <= drive_en(p2_dir,
				port_config_reg_q[`IRIO_CFG_P2_PUSHPULL],
				p2_data_q); // [R6]
			port2_pullup_en <= ~p2_dir; // [R4]
			// fixed outputs are always push-pull, no enable
			port3_out[4] <= cfg_comp ? cmp1_s :
				counter_ctl_1_q[`IRIO_COUNTER_CTL_1_T8_OUT] ? timer8_out :
				p3_data_q[4]; // [R14] [R18] [R10]
			port3_out[5] <= counter_ctl_0_q[`IRIO_COUNTER_CTL_0_T16_OUT] ?
				timer16_out : p3_data_q[5]; // [R14]
			port3_out[6] <= counter_ctl_1_q[`IRIO_COUNTER_CTL_1_T816_OUT] ?
				timer816_out : p3_data_q[6]; // [R14]
			port3_out[7] <= cfg_comp ? cmp2_s :
				counter_ctl_2_q[`IRIO_COUNTER_CTL_2_LOGIC_OUT] ?
				wake_request : p3_data_q[7]; // [R14] [R18]
			comp_power_en <= analog & ~stop_mode; // [R17] [R11]
			// port2_bit0 only reaches the detector in demodulation
			timer_edge_in <= (tmr_common_q[`IRIO_TMR_SEL_P2] &
				tmr_common_q[`IRIO_TMR_DEMOD]) ?
				p2_sync_q[0] : src1; // [R9] [R13]
			wake_request <= wake_ctl_q[`IRIO_WAKE_EN] &
				(wake_ctl_q[`IRIO_WAKE_AND] ? &p2_sync_q :
				|p2_sync_q); // [R8]
			stop_recovery_in3 <= analog & in3_s; // [R15]
			ext_int_2 <= ~src_swap & edge_hit(edge_sel,
				irq_src_prev_q[0], src1); // [R12]
			ext_int_0 <= ~src_swap & edge_hit(edge_sel,
				irq_src_prev_q[1], src2); // [R12]
			// falling edge; suppressed while diverted in analog mode
			ext_int_1 <= ~analog & irq_src_prev_q[2] &
				~in3_s; // [R16] [R15]
		end
	end

endmodule // irio_ports

`default_nettype wire

// ---- tb/irio_pins.sv ----
// board model of one 8-bit port: driven lines and released lines
`default_nettype none
module irio_pins (
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_oe,
	input wire logic [7:0] ext_drive,
	output logic [7:0] pin_in
);
	// ------------------------------------------------
	// line levels
	// ------------------------------------------------
	// a released line shows the board drive, never the last output
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_drive);
endmodule // irio_pins
`default_nettype wire

// ---- tb/irio_ports_checker.sv ----
// concurrent checks on the port block pins
`default_nettype none
module irio_ports_checker (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] readdata,
	input wire logic waitrequest,
	input wire logic [7:0] port0_pullup_en,
	input wire logic [7:0] port0_oe,
	input wire logic [7:0] port2_oe,
	input wire logic [7:0] port2_pullup_en,
	input wire logic [3:1] port3_in,
	input wire logic stop_mode,
	input wire logic comp_power_en,
	input wire logic wake_request,
	input wire logic ext_int_1,
	input wire logic ext_int_2
);
	// ------------------------------------------------
	// checks
	// ------------------------------------------------
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!reset_n);
	wait_one_a: assert property (!waitrequest |=> waitrequest)
		else $error("wait low twice");
	wait_ans_a: assert property ((read || write) && waitrequest
		|=> !waitrequest) else $error("no answer");
	rdata_hi_a: assert property (readdata[31:8] == 24'h0)
		else $error("read upper bits set");
	pull_off0_a: assert property ((port0_oe & port0_pullup_en) == 8'h0)
		else $error("pull-up on driven first port pin");
	pull_off2_a: assert property ((port2_oe & port2_pullup_en) == 8'h0)
		else $error("pull-up on driven second port pin");
	nibble_dir_a: assert property (
		port0_pullup_en[3:0] == {4{port0_pullup_en[0]}} &&
		port0_pullup_en[7:4] == {4{port0_pullup_en[4]}})
		else $error("first port direction split in nibble");
	int1_fall_a: assert property (ext_int_1 |-> !$past(port3_in[3], 3))
		else $error("ext_int_1 without low input");
	int1_pulse_a: assert property (ext_int_1 |=> !ext_int_1)
		else $error("ext_int_1 wider than one cycle");
	stop_pwr_a: assert property (stop_mode [*2] |-> !comp_power_en)
		else $error("comparators powered in stop");
	cover property (ext_int_2);
	cover property (wake_request);
	cover property (read && !waitrequest);
endmodule // irio_ports_checker
bind irio_ports irio_ports_checker u_irio_ports_checker (
	.clock(clock), .reset_n(reset_n), .read(read), .write(write),
	.readdata(readdata), .waitrequest(waitrequest),
	.port0_pullup_en(port0_pullup_en), .port0_oe(port0_oe),
	.port2_oe(port2_oe), .port2_pullup_en(port2_pullup_en),
	.port3_in(port3_in), .stop_mode(stop_mode),
	.comp_power_en(comp_power_en), .wake_request(wake_request),
	.ext_int_1(ext_int_1), .ext_int_2(ext_int_2)
);
`default_nettype wire

// ---- tb/tb_irio_ports.sv ----
// self-checking bench for the port block
`default_nettype none
module tb_irio_ports;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock, reset_n, read, write, c1, c2, t8, t16, t816, stp;
	logic [5:0] address;
	logic [31:0] writedata, readdata, rd;
	logic [3:0] byteenable;
	logic waitrequest, cpe, tei, wk, sr3, i0, i1, i2;
	logic [7:0] p0i, p0o, p0e, p0u, p2i, p2o, p2e, p2u, d0, d2;
	logic [3:1] p3i;
	logic [7:4] p3o;
	int mismatches = 0, comparisons = 0, cyc = 0;
	int n0 = 0, n1 = 0, n2 = 0, m0, m1, m2, k;
	int ex[3] = '{1, 1, 2};
	// ------------------------------------------------
	// design, board and clock
	// ------------------------------------------------
	irio_ports u_irio_ports (.clock(clock), .reset_n(reset_n),
		.address(address), .read(read), .write(write),
		.writedata(writedata), .byteenable(byteenable),
		.readdata(readdata), .waitrequest(waitrequest),
		.port0_in(p0i), .port0_out(p0o), .port0_oe(p0e),
		.port0_pullup_en(p0u), .port2_in(p2i), .port2_out(p2o),
		.port2_oe(p2e), .port2_pullup_en(p2u), .port3_in(p3i),
		.port3_out(p3o), .comp1_result(c1), .comp2_result(c2),
		.timer8_out(t8), .timer16_out(t16), .timer816_out(t816),
		.stop_mode(stp), .comp_power_en(cpe), .timer_edge_in(tei),
		.wake_request(wk), .stop_recovery_in3(sr3),
		.ext_int_0(i0), .ext_int_1(i1), .ext_int_2(i2));
	irio_pins u_irio_pins (.pin_out(p0o), .pin_oe(p0e),
		.ext_drive(d0), .pin_in(p0i));
	irio_pins u_irio_pins_2 (.pin_out(p2o), .pin_oe(p2e),
		.ext_drive(d2), .pin_in(p2i));
	initial begin
		clock = 0;
		forever #2 clock = ~clock;
	end
	// pulse counters; ceiling far above the ~335 cycles the run needs
	always @(posedge clock) begin
		cyc <= cyc + 1;
		n0 <= n0 + (i0 === 1'b1);
		n1 <= n1 + (i1 === 1'b1);
		n2 <= n2 + (i2 === 1'b1);
		if (cyc == 5000) begin
			mismatches = mismatches + 1;
			finish_test;
		end
	end
	// ------------------------------------------------
	// tasks
	// ------------------------------------------------
	task finish_test;
		if (mismatches == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		comparisons = comparisons + 1;
		if (g !== e) begin
			mismatches = mismatches + 1;
			$display("ERROR %0t got %h expected %h", $time, g, e);
		end
	endtask
	task acc(input logic w, input logic [5:0] a, input logic [7:0] d);
		@(posedge clock);
		read <= !w;
		write <= w;
		address <= a;
		writedata <= {24'h0, d};
		do @(posedge clock); while (waitrequest !== 1'b0);
		rd = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask
	task wr(input logic [5:0] a, input logic [7:0] d);
		acc(1'b1, a, d);
	endtask
	task rchk(input logic [5:0] a, input logic [7:0] e);
		acc(1'b0, a, 8'h0);
		chk(rd, {24'h0, e});
	endtask
	// sync, register and pulse stages all land within this wait
	task st;
		repeat (8) @(posedge clock);
	endtask
	// ------------------------------------------------
	// main sequence
	// ------------------------------------------------
	initial begin
		{reset_n, read, write, c1, c2, t16, stp} = 7'h0;
		{t8, t816} = 2'h3;
		address = 6'h0;
		writedata = 32'h0;
		byteenable = 4'hf;
		{d0, d2} = 16'h0;
		p3i = 3'h0;
		repeat (3) @(posedge clock);
		reset_n <= 1'b1;
		@(posedge clock);
		chk(p0e, 8'h0);
		chk(p2u, 8'hff);
		rchk(6'h00, 8'h00);
		rchk(6'h08, 8'hff);
		rchk(6'h3c, 8'h00);
		byteenable <= 4'he;
		wr(6'h00, 8'h03);
		byteenable <= 4'hf;
		rchk(6'h00, 8'h00);
		wr(6'h04, 8'h04);
		wr(6'h10, 8'h5a);
		wr(6'h00, 8'h01);
		d0 <= 8'h3c;
		st;
		chk(p0e, 8'h0f);
		chk(p0u, 8'hf0);
		chk(p0o, 8'h5a);
		rchk(6'h10, 8'h3a);
		wr(6'h04, 8'h00);
		wr(6'h00, 8'h03);
		st;
		chk(p0e, 8'ha5);
		chk(p0u, 8'h00);
		wr(6'h04, 8'h02);
		wr(6'h14, 8'h0c);
		wr(6'h08, 8'hf0);
		st;
		chk(p2e, 8'h0f);
		chk(p2u, 8'hf0);
		chk(p2o, 8'h0c);
		wr(6'h04, 8'h00);
		st;
		chk(p2e, 8'h03);
		wr(6'h08, 8'hff);
		wr(6'h30, 8'h01);
		st;
		chk(wk, 1'b0);
		d2 <= 8'h10;
		st;
		chk(wk, 1'b1);
		wr(6'h30, 8'h03);
		st;
		chk(wk, 1'b0);
		d2 <= 8'hff;
		wr(6'h28, 8'h01);
		wr(6'h2c, 8'h03);
		st;
		chk(wk, 1'b1);
		chk(tei, 1'b1);
		d2 <= 8'hfe;
		st;
		chk(tei, 1'b0);
		d2 <= 8'hff;
		wr(6'h2c, 8'h00);
		p3i <= 3'h1;
		st;
		chk(tei, 1'b1);
		wr(6'h20, 8'h01);
		wr(6'h24, 8'h30);
		st;
		chk(p3o, 4'hd);
		wr(6'h04, 8'h01);
		st;
		chk(p3o, 4'h4);
		{c1, c2} <= 2'h3;
		st;
		chk(p3o, 4'hd);
		{c1, c2} <= 2'h0;
		p3i <= 3'h0;
		for (k = 0; k < 3; k++) begin
			wr(6'h1c, 8'(k << 6));
			st;
			m0 = n0;
			m2 = n2;
			p3i <= 3'h3;
			st;
			p3i <= 3'h0;
			st;
			chk(n2 - m2, ex[k]);
			chk(n0 - m0, ex[k]);
		end
		m1 = n1;
		p3i <= 3'h4;
		st;
		acc(1'b0, 6'h18, 8'h0);
		chk(rd[3:1], 3'h4);
		p3i <= 3'h0;
		st;
		chk(n1 - m1, 1);
		p3i <= 3'h3;
		st;
		m0 = n0;
		m2 = n2;
		wr(6'h0c, 8'h02);
		st;
		chk(n2 - m2, 0);
		chk(n0 - m0, 0);
		m1 = n1;
		p3i <= 3'h4;
		st;
		chk(sr3, 1'b1);
		acc(1'b0, 6'h18, 8'h0);
		chk(rd[3], 1'b0);
		p3i <= 3'h0;
		m2 = n2;
		c1 <= 1'b1;
		st;
		c1 <= 1'b0;
		st;
		chk(n1 - m1, 0);
		chk(n2 - m2, 2);
		chk(cpe, 1'b1);
		stp <= 1'b1;
		st;
		chk(cpe, 1'b0);
		finish_test;
	end
endmodule // tb_irio_ports
`default_nettype wire
